// [flash_port.sv]
// two-wire slave port with register file of the flash driver
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// (RL1) answer only bus address 011 0011, ignore every other address
// (RL2) work at 100 kbps, 400 kbps and 3.4 Mbps bus rates
// (RL3) seven-bit addressing only; no ten-bit or general call answer
// (RL4) data falling while clock high is a start
// (RL5) data rising while clock high is a stop; bus then free
// (RL6) on address match hold data low through the ninth clock high
// (RL7) master keeps data stable while clock is high
// (RL8) the receiver of each byte acknowledges it
// (RL9) bytes move as eight data bits plus one acknowledge bit
// (RL10) reading an unimplemented register returns 00h
// (RL11) master code 00001xxx is not acknowledged but selects high-speed
// (RL12) after master code a repeated start begins normal protocol
// (RL13) a stop ends high-speed operation
// (RL14) master uses repeated starts to stay in high-speed
// (RL15) a write is start, address, register index, data byte
// (RL16) acknowledge every received byte during the next clock high
// (RL17) commit written data at the falling edge ending its acknowledge
// (RL18) first byte after a start is the slave address
// (RL19) register byte low three bits select the register
// (RL20) hardware reset pin clears port and registers, enters shutdown
// (RL21) direction bit zero writes, one reads
module flash_port
    import flash_port_pkg::*;
#(
    parameter int IMPL_REGS = NUM_IMPL
) (
    input  wire logic                  ref_clk,
    input  wire logic                  arst_n,
    input  wire logic                  scl_in,
    input  wire logic                  sda_in,
    input  wire logic                  hw_reset_n,
    output logic                       sda_out,
    output logic                       sda_oe,
    output logic [NUM_REGS*8-1:0]      reg_out,
    output logic                       hs_mode,
    output logic                       shutdown
);
    logic                 rst_meta_q;
    logic                 rst_q;
    logic                 rst_n;
    pin_set_t             pins_q;
    bus_event_t           ev;
    logic                 port_clear;
    port_state_t          state_q;
    byte_kind_t           kind_q;
    logic [3:0]           cnt_q;
    logic [7:0]           shift_q;
    logic [7:0]           tx_q;
    logic [REG_IDX_W-1:0] ptr_q;
    logic                 rw_q;
    logic                 mack_q;
    logic                 drive_q;
    logic                 hs_q;
    logic                 shut_q;
    logic                 byte_done;
    logic                 commit;
    logic [REG_IDX_W-1:0] ptr_next;
    logic [7:0]           rd_now;
    logic [7:0]           rd_next;
    pin_set_t             pins_raw;
    logic [7:0]           regs_q [NUM_REGS];

    function automatic logic [7:0] rd_val(input logic [REG_IDX_W-1:0] idx);
        // (RL10) unmapped reads as zero
        if (int'(idx) < IMPL_REGS) begin
            rd_val = regs_q[idx];
        end else begin
            rd_val = UNMAPPED;
        end
    endfunction

    assign ptr_next = ptr_q + REG_IDX_W'(1);

    always_comb begin
        rd_now  = rd_val(ptr_q);
        rd_next = rd_val(ptr_next);
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_q <= 1'b0;
            rst_q      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_q      <= rst_meta_q;
        end
    end

    assign rst_n = rst_q;

    assign pins_raw = '{scl: scl_in, sda: sda_in, hw_reset_n: hw_reset_n};

    // (RL2) oversampled pins serve all rates
    pin_sync u_sync (
        .clk     (ref_clk),
        .rst_n   (rst_n),
        .pins_in (pins_raw),
        .pins_q  (pins_q),
        .ev      (ev)
    );

    // (RL20) pin reset clears the port
    assign port_clear = !pins_q.hw_reset_n;
    assign byte_done  = state_q == ST_RX && ev.scl_fall && cnt_q == BYTE_BITS;
    // (RL17) commit at end of data ack
    assign commit     = state_q == ST_ACK && ev.scl_fall && kind_q == BY_DATA;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            kind_q  <= BY_ADDR;
            cnt_q   <= 4'h0;
            shift_q <= 8'h00;
            tx_q    <= 8'h00;
            ptr_q   <= '0;
            rw_q    <= 1'b0;
            mack_q  <= 1'b0;
            drive_q <= 1'b0;
        end else if (port_clear || ev.stop) begin
            // (RL5) bus free after stop
            state_q <= ST_IDLE;
            drive_q <= 1'b0;
            if (port_clear) begin
                ptr_q <= '0;
            end
        end else if (ev.start) begin
            // (RL18) first byte is address
            // (RL12) repeated start restarts protocol
            state_q <= ST_RX;
            kind_q  <= BY_ADDR;
            cnt_q   <= 4'h0;
            drive_q <= 1'b0;
        end else begin
            case (state_q)
                ST_RX: begin
                    // (RL7) sample on clock rise
                    if (ev.scl_rise && cnt_q != BYTE_BITS) begin
                        shift_q <= {shift_q[6:0], pins_q.sda};
                        cnt_q   <= cnt_q + 4'h1;
                    end else if (byte_done) begin
                        cnt_q <= 4'h0;
                        case (kind_q)
                            BY_ADDR: begin
                                // (RL1) address match
                                // (RL3) seven-bit compare only
                                if (shift_q[7:1] == SLAVE_ADDR) begin
                                    // (RL6) ack drive on match
                                    state_q <= ST_ACK;
                                    drive_q <= 1'b1;
                                    // (RL21) direction bit
                                    rw_q    <= shift_q[0];
                                end else begin
                                    state_q <= ST_SKIP;
                                end
                            end
                            BY_REG: begin
                                // (RL19) low three bits index
                                ptr_q   <= shift_q[REG_IDX_W-1:0];
                                state_q <= ST_ACK;
                                drive_q <= 1'b1;
                            end
                            default: begin
                                // (RL16) ack received byte
                                state_q <= ST_ACK;
                                drive_q <= 1'b1;
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    if (ev.scl_fall) begin
                        drive_q <= 1'b0;
                        if (kind_q == BY_ADDR && rw_q) begin
                            tx_q    <= rd_now;
                            drive_q <= !rd_now[7];
                            state_q <= ST_TX;
                            kind_q  <= BY_DATA;
                            cnt_q   <= 4'h0;
                        end else begin
                            // (RL15) address, index, then data
                            if (kind_q == BY_DATA) begin
                                ptr_q <= ptr_next;
                            end
                            kind_q  <= (kind_q == BY_ADDR) ? BY_REG : BY_DATA;
                            state_q <= ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    if (ev.scl_fall) begin
                        // (RL9) eight bits then acknowledge slot
                        if (cnt_q == LAST_TX_BIT) begin
                            drive_q <= 1'b0;
                            state_q <= ST_MACK;
                        end else begin
                            cnt_q   <= cnt_q + 4'h1;
                            tx_q    <= {tx_q[6:0], 1'b0};
                            drive_q <= !tx_q[6];
                        end
                    end
                end
                ST_MACK: begin
                    // (RL8) master acknowledges read bytes
                    if (ev.scl_rise) begin
                        mack_q <= !pins_q.sda;
                    end else if (ev.scl_fall) begin
                        if (mack_q) begin
                            ptr_q   <= ptr_next;
                            tx_q    <= rd_next;
                            drive_q <= !rd_next[7];
                            cnt_q   <= 4'h0;
                            state_q <= ST_TX;
                        end else begin
                            state_q <= ST_SKIP;
                        end
                    end
                end
                default: begin
                    drive_q <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_q[i] <= REG_RESET;
            end
        end else if (port_clear) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_q[i] <= REG_RESET;
            end
        end else if (commit && int'(ptr_q) < IMPL_REGS) begin
            regs_q[ptr_q] <= shift_q;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hs_q <= 1'b0;
        end else if (byte_done && kind_q == BY_ADDR && shift_q[7:3] == HS_CODE_TOP) begin
            // (RL11) master code selects high-speed
            hs_q <= 1'b1;
        end else if (port_clear || ev.stop) begin
            // (RL13) stop leaves high-speed
            hs_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            shut_q <= 1'b1;
        end else begin
            shut_q <= port_clear;
        end
    end

    for (genvar g = 0; g < NUM_REGS; g++) begin : g_out
        assign reg_out[g*8 +: 8] = regs_q[g];
    end

    assign sda_out  = 1'b0;
    assign sda_oe   = drive_q;
    assign hs_mode  = hs_q;
    assign shutdown = shut_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n || port_clear);

    sequence addr_done_s;
        byte_done && kind_q == BY_ADDR;
    endsequence

    addr_ack_a: assert property ( // (RL6)
        addr_done_s ##0 shift_q[7:1] == SLAVE_ADDR && !ev.start && !ev.stop |=> sda_oe
    ) else $error("matching address not acknowledged");

    foreign_addr_a: assert property ( // (RL1)
        addr_done_s ##0 shift_q[7:1] != SLAVE_ADDR && !ev.stop && !ev.start
            |=> !sda_oe && state_q == ST_SKIP
    ) else $error("foreign address answered");

    hs_code_a: assert property ( // (RL11)
        addr_done_s ##0 shift_q[7:3] == HS_CODE_TOP && !ev.stop && !ev.start
            |=> hs_mode && !sda_oe
    ) else $error("master code mishandled");

    stop_hs_a: assert property ( // (RL13)
        ev.stop |=> !hs_mode
    ) else $error("high-speed kept after stop");

    ack_hold_a: assert property ( // (RL16)
        state_q == ST_ACK |-> sda_oe
    ) else $error("ack released early");

    commit_data_a: assert property ( // (RL17)
        commit && int'(ptr_q) < IMPL_REGS |=> regs_q[$past(ptr_q)] == $past(shift_q)
    ) else $error("write not committed");

    unmapped_rd_a: assert property ( // (RL10)
        state_q == ST_ACK && ev.scl_fall && kind_q == BY_ADDR && rw_q
            && int'(ptr_q) >= IMPL_REGS && !ev.start && !ev.stop |=> tx_q == UNMAPPED
    ) else $error("unmapped read not zero");

    start_addr_a: assert property ( // (RL18)
        ev.start && !ev.stop |=> state_q == ST_RX && kind_q == BY_ADDR && cnt_q == 4'h0
    ) else $error("start did not arm address byte");

    stop_idle_a: assert property ( // (RL5)
        ev.stop |=> state_q == ST_IDLE && !sda_oe
    ) else $error("bus not freed by stop");
endmodule
`default_nettype wire

// [flash_port_pkg.sv]
// shared constants and types of the flash driver serial slave port
package flash_port_pkg;

    localparam logic [6:0] SLAVE_ADDR  = 7'h33;
    localparam logic [4:0] HS_CODE_TOP = 5'h01;
    localparam int         NUM_REGS    = 8;
    localparam int         REG_IDX_W   = 3;
    localparam int         NUM_IMPL    = 4;
    localparam logic [7:0] REG_RESET   = 8'h00;
    localparam logic [7:0] UNMAPPED    = 8'h00;
    localparam logic [3:0] BYTE_BITS   = 4'h8;
    localparam logic [3:0] LAST_TX_BIT = 4'h7;
    localparam logic [1:0] RST_SYNC    = 2'h0;

    typedef struct packed {
        logic scl;
        logic sda;
        logic hw_reset_n;
    } pin_set_t;

    typedef struct packed {
        logic start;
        logic stop;
        logic scl_rise;
        logic scl_fall;
    } bus_event_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX   = 3'b001,
        ST_ACK  = 3'b010,
        ST_TX   = 3'b011,
        ST_MACK = 3'b100,
        ST_SKIP = 3'b101
    } port_state_t;

    typedef enum logic [1:0] {
        BY_ADDR = 2'b00,
        BY_REG  = 2'b01,
        BY_DATA = 2'b10
    } byte_kind_t;

endpackage

// [pin_sync.sv]
// pin synchroniser and bus condition detector
`timescale 1ns/1ps
`default_nettype none
module pin_sync
    import flash_port_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire pin_set_t   pins_in,
    output var pin_set_t    pins_q,
    output var bus_event_t  ev
);
    pin_set_t meta_q;
    pin_set_t sync_q;
    pin_set_t prev_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '{scl: 1'b1, sda: 1'b1, hw_reset_n: 1'b0};
            sync_q <= '{scl: 1'b1, sda: 1'b1, hw_reset_n: 1'b0};
            prev_q <= '{scl: 1'b1, sda: 1'b1, hw_reset_n: 1'b0};
        end else begin
            meta_q <= pins_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign pins_q = sync_q;

    always_comb begin
        // (RL4) start detect
        ev.start    = prev_q.scl && sync_q.scl && prev_q.sda && !sync_q.sda;
        // (RL5) stop detect
        ev.stop     = prev_q.scl && sync_q.scl && !prev_q.sda && sync_q.sda;
        ev.scl_rise = !prev_q.scl && sync_q.scl;
        ev.scl_fall = prev_q.scl && !sync_q.scl;
    end
endmodule
`default_nettype wire

// [bus_master.sv]
// two-wire bus master model for the flash port bench
`timescale 1ns/1ps
`default_nettype none
module bus_master (
    input  wire logic clk,
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda
);
    int q = 16;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic start();
        // keep pin changes off the sampling edge
        @(negedge clk);
        sda_low = 1'b0;
        #q scl = 1'b1;
        #q sda_low = 1'b1;
        #q scl = 1'b0;
        #q;
    endtask
    task automatic stop();
        @(negedge clk);
        sda_low = 1'b1;
        #q scl = 1'b1;
        #q sda_low = 1'b0;
        #q;
    endtask
    task automatic put_bit(input logic b);
        sda_low = ~b;
        #q scl = 1'b1;
        #(2*q) scl = 1'b0;
        #q;
    endtask
    task automatic get_bit(output logic b);
        sda_low = 1'b0;
        #q scl = 1'b1;
        #q b = sda;
        #q scl = 1'b0;
        #q;
    endtask
    task automatic send(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--)
            put_bit(d[i]);
        get_bit(b);
        ack = ~b;
    endtask
    task automatic recv(input logic more, output logic [7:0] d);
        for (int i = 7; i >= 0; i--)
            get_bit(d[i]);
        put_bit(~more);
    endtask
endmodule
`default_nettype wire

// [flash_port_tb.sv]
// self-checking bench of the flash driver serial slave port
`timescale 1ns/1ps
`default_nettype none
module flash_port_tb;
    import flash_port_pkg::*;
    logic                  ref_clk;
    logic                  arst_n;
    logic                  hw_reset_n;
    logic                  scl;
    logic                  m_low;
    logic                  sda_oe;
    logic                  sda_drv;
    logic [NUM_REGS*8-1:0] reg_out;
    logic                  hs_mode;
    logic                  shutdown;
    wire logic             sda;
    int                    error_cnt;
    int                    samples_checked;
    logic                  ack;
    logic [7:0]            rd;
    logic [6:0]            bad [3];
    // open-drain data line with pull-up
    assign sda = ~(m_low | (sda_oe & ~sda_drv));
    initial ref_clk = 1'b0;
    always #2.5 ref_clk = ~ref_clk;
    flash_port u_flash_port (
        .ref_clk    (ref_clk),
        .arst_n     (arst_n),
        .scl_in     (scl),
        .sda_in     (sda),
        .hw_reset_n (hw_reset_n),
        .sda_out    (sda_drv),
        .sda_oe     (sda_oe),
        .reg_out    (reg_out),
        .hs_mode    (hs_mode),
        .shutdown   (shutdown)
    );
    bus_master u_bus_master (
        .clk     (ref_clk),
        .scl     (scl),
        .sda_low (m_low),
        .sda     (sda)
    );
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
        u_bus_master.start();
        u_bus_master.send({SLAVE_ADDR, 1'b0}, ack);
        check(ack, 1'b1);
        u_bus_master.send(idx, ack);
        check(ack, 1'b1);
        u_bus_master.send(d, ack);
        check(ack, 1'b1);
        repeat (5) @(posedge ref_clk);
    endtask
    task automatic rd_reg(input logic [7:0] idx);
        wr_reg(idx, 8'hc3);
        u_bus_master.start();
        u_bus_master.send({SLAVE_ADDR, 1'b0}, ack);
        u_bus_master.send(idx, ack);
        u_bus_master.start();
        u_bus_master.send({SLAVE_ADDR, 1'b1}, ack);
        check(ack, 1'b1);
        u_bus_master.recv(1'b0, rd);
        u_bus_master.stop();
    endtask
    task automatic t_after_reset();
        check(reg_out, '0);
        check(shutdown, 1'b0);
        check(hs_mode, 1'b0);
        $display("after_reset done");
    endtask
    task automatic t_write_read();
        wr_reg(8'h01, 8'ha5);
        check(reg_out[15:8], 8'ha5);
        u_bus_master.stop();
        wr_reg(8'h02, 8'h3c);
        check(reg_out[23:16], 8'h3c);
        u_bus_master.stop();
        u_bus_master.start();
        u_bus_master.send({SLAVE_ADDR, 1'b0}, ack);
        u_bus_master.send(8'h01, ack);
        u_bus_master.start();
        u_bus_master.send({SLAVE_ADDR, 1'b1}, ack);
        check(ack, 1'b1);
        u_bus_master.recv(1'b1, rd);
        check(rd, 8'ha5);
        u_bus_master.recv(1'b0, rd);
        check(rd, 8'h3c);
        u_bus_master.stop();
        rd_reg(8'h06);
        check(rd, UNMAPPED);
        $display("write_read done");
    endtask
    task automatic t_foreign();
        bad = '{7'h32, 7'h00, 7'h78};
        foreach (bad[i]) begin
            u_bus_master.start();
            u_bus_master.send({bad[i], 1'b0}, ack);
            check(ack, 1'b0);
            u_bus_master.send(8'h01, ack);
            u_bus_master.send(8'hff, ack);
            check(ack, 1'b0);
            u_bus_master.stop();
        end
        check(reg_out[15:8], 8'ha5);
        $display("foreign done");
    endtask
    task automatic t_hs();
        u_bus_master.start();
        u_bus_master.send({HS_CODE_TOP, 3'h5}, ack);
        check(ack, 1'b0);
        repeat (5) @(posedge ref_clk);
        check(hs_mode, 1'b1);
        u_bus_master.q = 12;
        wr_reg(8'h03, 8'h5a);
        check(reg_out[31:24], 8'h5a);
        check(hs_mode, 1'b1);
        u_bus_master.stop();
        repeat (6) @(posedge ref_clk);
        check(hs_mode, 1'b0);
        u_bus_master.q = 16;
        $display("hs done");
    endtask
    task automatic t_hw_reset();
        @(posedge ref_clk);
        hw_reset_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        check(shutdown, 1'b1);
        check(reg_out, '0);
        hw_reset_n <= 1'b1;
        repeat (10) @(posedge ref_clk);
        check(shutdown, 1'b0);
        $display("hw_reset done");
    endtask
    initial begin
        error_cnt = 0;
        samples_checked = 0;
        arst_n = 1'b0;
        hw_reset_n = 1'b1;
        repeat (6) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (20) @(posedge ref_clk);
        t_after_reset();
        t_write_read();
        t_foreign();
        t_hs();
        t_hw_reset();
        wrap_up();
    end
    initial begin
        #200000;
        error_cnt++;
        wrap_up();
    end
endmodule
`default_nettype wire
